// ===== irq_consts.vh
// Constants for the interrupt request block and its time base.
// Included by every design file; holds definitions only.
`ifndef IRQ_CONSTS_VH
`define IRQ_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets (8-bit registers, 5-bit address)
// ----------------------------------------------------------------
`define OFS_PSC_SRC     5'h00
`define OFS_TICK_CTRL   5'h01
`define OFS_CORE_CTRL   5'h02
`define OFS_IRQ_EN      5'h03
`define OFS_IRQ_FLAG    5'h04
`define OFS_CONV_CTRL   5'h05
`define OFS_UPPER_BOUND 5'h06
`define OFS_LOWER_BOUND 5'h07
`define OFS_CAPTURE     5'h08
`define OFS_PWM         5'h09
`define OFS_TMR_EN      5'h0A
`define OFS_TMR_FLAG    5'h0B
`define OFS_STATUS      5'h0C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TICK_ON_BIT     7
`define PSC_SRC_MASK    8'h03
`define TICK_CTRL_MASK  8'h87
`define CONV_DONE_FBIT  6
`define CONV_LIM_FBIT   7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PSC_SRC_RST     2'h0
`define TICK_CTRL_RST   8'h00
`define REG8_RST        8'h00

// ----------------------------------------------------------------
// Prescaler sources and time base figures
// ----------------------------------------------------------------
`define PSC_SYS         2'h0
`define PSC_SYS_DIV4    2'h1
`define PSC_DIV         4
`define TICK_BASE_EXP   8
`define TICK_CNT_W      15

// ----------------------------------------------------------------
// Vector identities, highest priority first
// ----------------------------------------------------------------
`define VEC_PROTECT     3'h0
`define VEC_LOW_SUPPLY  3'h1
`define VEC_GROUP0      3'h2
`define VEC_TICK        3'h6
`define N_REQ           7

`endif

// ===== sync2.v
// Two flip-flop synchroniser for levels from outside the clock domain.
// Assumes each bit is an independent slow level or clock.
`timescale 1ns/1ps
`include "irq_consts.vh"

module sync2 #(
    parameter W = 3
) (
    input wire clk,
    input wire rst,
    input wire [W-1:0] d,
    output reg [W-1:0] q_r
);

reg [W-1:0] meta_r;

always @(posedge clk or posedge rst) begin
    if (rst) begin
        meta_r <= {W{1'b0}};
        q_r <= {W{1'b0}};
    end else begin
        meta_r <= d;
        q_r <= meta_r;
    end
end

endmodule

// ===== tick_gen.v
// Time base: prescaler clock select and power-of-two period divider.
// Assumes sub_rise is a one-cycle pulse per synchronised sub clock rising edge.
`timescale 1ns/1ps
`include "irq_consts.vh"

module tick_gen (
    input wire clk,
    input wire rst,
    input wire on,
    input wire [1:0] src,
    input wire [2:0] period,
    input wire sub_rise,
    output reg tick_r
);

reg [1:0] div4_r;
reg [`TICK_CNT_W-1:0] cnt_r;
reg psc_en;
wire [`TICK_CNT_W-1:0] mask;
wire wrap;

always @* begin
    case (src)
        `PSC_SYS: psc_en = 1'b1;
        `PSC_SYS_DIV4: psc_en = ({30'h0, div4_r} == `PSC_DIV - 1);
        default: psc_en = sub_rise;
    endcase
end

// period is two to eight plus field
assign mask = ~({`TICK_CNT_W{1'b1}} << (`TICK_BASE_EXP + period));
assign wrap = ((cnt_r & mask) == mask);

always @(posedge clk or posedge rst) begin
    if (rst) begin
        div4_r <= 2'h0;
        cnt_r <= {`TICK_CNT_W{1'b0}};
        tick_r <= 1'b0;
    end else begin
        div4_r <= div4_r + 2'h1;
        tick_r <= 1'b0;
        if (!on) begin
            cnt_r <= {`TICK_CNT_W{1'b0}};
        end else if (psc_en) begin
            cnt_r <= wrap ? {`TICK_CNT_W{1'b0}} : cnt_r + 1'b1;
            tick_r <= wrap;
        end
    end
end

endmodule

// ===== irq_ctrl.v
// Interrupt request flags, group flags, vectoring and time base.
// Assumes peripheral events are one-cycle pulses on sys_clk; protection,
// low supply and sub clock come from outside and are synchronised here.
`timescale 1ns/1ps
`include "irq_consts.vh"

module irq_ctrl #(
    parameter N_TMR = 2
) (
    input wire sys_clk,
    input wire rst,
    input wire [4:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] rd_data_r,
    input wire overcurrent_protect_signal,
    input wire low_supply_detect,
    input wire sub_clk,
    input wire conv_done_evt,
    input wire [7:0] conv_result,
    input wire capture_overflow_evt,
    input wire capture_compare_evt,
    input wire period_match_evt,
    input wire [2:0] duty_match_evt,
    input wire [N_TMR-1:0] timer_p_match_evt,
    input wire [N_TMR-1:0] timer_a_match_evt,
    input wire stack_full,
    input wire reti_evt,
    output reg vec_call_r,
    output reg [2:0] vec_id_r,
    output reg wake_r,
    output reg global_irq_enable_r
);

// ----------------------------------------------------------------
// Member layout
// ----------------------------------------------------------------
// Bit 0 done, 1 limit, 2 overflow, 3 compare, 4 period, 5..7 duty,
// then timer n at 8+2n (P) and 9+2n (A).
localparam MW = 8 + 2 * N_TMR;
localparam TW = 2 * N_TMR;

reg [1:0] prescaler_source_r;
reg [2:0] tick_period_select_r;
reg tick_generator_on_r, protect_irq_enable_r, tick_irq_enable_r, low_supply_enable_r;
reg protect_irq_flag_r, tick_flag_r, low_supply_flag_r;
reg upper_bound_trigger_en_r, lower_bound_trigger_en_r, oc_prev_r, lvd_prev_r, sub_prev_r;
reg [3:0] group_en_r, group_irq_flag_r;
reg [7:0] upper_bound_r, lower_bound_r;
reg [MW-1:0] mem_en_r, mem_flag_r;

wire [2:0] sync_q;
wire tick_pulse;

// ----------------------------------------------------------------
// Inputs from outside the clock domain
// ----------------------------------------------------------------
sync2 #(.W(3)) u_sync (
    .clk(sys_clk),
    .rst(rst),
    .d({sub_clk, low_supply_detect, overcurrent_protect_signal}),
    .q_r(sync_q)
);

wire oc_s = sync_q[0];
wire lvd_s = sync_q[1];
wire sub_s = sync_q[2];
wire sub_rise = sub_s & ~sub_prev_r;

// ----------------------------------------------------------------
// Time base
// ----------------------------------------------------------------
tick_gen u_tick (
    .clk(sys_clk),
    .rst(rst),
    .on(tick_generator_on_r),
    .src(prescaler_source_r),
    .period(tick_period_select_r),
    .sub_rise(sub_rise),
    .tick_r(tick_pulse)
);

// ----------------------------------------------------------------
// Register write decode
// ----------------------------------------------------------------
wire wr_core = reg_wr & (reg_addr == `OFS_CORE_CTRL);
wire wr_en = reg_wr & (reg_addr == `OFS_IRQ_EN);
wire wr_flag = reg_wr & (reg_addr == `OFS_IRQ_FLAG);
wire wr_conv = reg_wr & (reg_addr == `OFS_CONV_CTRL);
wire wr_cap = reg_wr & (reg_addr == `OFS_CAPTURE);
wire wr_pwm = reg_wr & (reg_addr == `OFS_PWM);
wire wr_tmr_en = reg_wr & (reg_addr == `OFS_TMR_EN);
wire wr_tmr_flag = reg_wr & (reg_addr == `OFS_TMR_FLAG);

// Flags clear by writing zero; writing one leaves them alone.
wire [7:0] zero_bits = ~reg_wdata;

// ----------------------------------------------------------------
// Member flags
// ----------------------------------------------------------------
wire [TW-1:0] tmr_set;

wire limit_hit = conv_done_evt &
    ((upper_bound_trigger_en_r & (conv_result > upper_bound_r)) |
     (lower_bound_trigger_en_r & (conv_result < lower_bound_r)));

genvar t;
generate
    for (t = 0; t < N_TMR; t = t + 1) begin : g_tmr
        assign tmr_set[2*t] = timer_p_match_evt[t];
        assign tmr_set[2*t+1] = timer_a_match_evt[t];
    end
endgenerate

// conversion and capture flags; period, duty and timer flags
wire [MW-1:0] mem_set = {tmr_set, duty_match_evt, period_match_evt,
                  capture_compare_evt, capture_overflow_evt,
                  limit_hit, conv_done_evt};

wire [MW-1:0] mem_clr = {{TW{wr_tmr_flag}} & zero_bits[TW-1:0],
                  {4{wr_pwm}} & zero_bits[7:4],
                  {2{wr_cap}} & zero_bits[5:4],
                  {2{wr_conv}} & zero_bits[7:6]};

// Set wins over a clear in the same cycle
wire [MW-1:0] mem_nxt = mem_set | (mem_flag_r & ~mem_clr);

// ----------------------------------------------------------------
// Group membership
// ----------------------------------------------------------------
wire [MW-1:0] mem_act = mem_flag_r & mem_en_r;
wire [3:0] grp_set, grp_act;

assign grp_set[0] = |mem_set[1:0];
assign grp_set[1] = |mem_set[3:2];
assign grp_set[2] = |mem_set[7:4];
assign grp_set[3] = |mem_set[MW-1:8];
// individual enable must also be set
assign grp_act[0] = |mem_act[1:0];
assign grp_act[1] = |mem_act[3:2];
assign grp_act[2] = |mem_act[7:4];
assign grp_act[3] = |mem_act[MW-1:8];

// ----------------------------------------------------------------
// Vectoring
// ----------------------------------------------------------------
wire [`N_REQ-1:0] req;
reg [`N_REQ-1:0] svc;
reg [2:0] svc_id;
integer k;

assign req[0] = protect_irq_flag_r & protect_irq_enable_r;
assign req[1] = low_supply_flag_r & low_supply_enable_r;
assign req[5:2] = group_irq_flag_r & group_en_r & grp_act;
assign req[6] = tick_flag_r & tick_irq_enable_r;

always @* begin
    svc = {`N_REQ{1'b0}};
    svc_id = `VEC_PROTECT;
    for (k = `N_REQ - 1; k >= 0; k = k - 1) begin
        if (req[k]) begin
            svc = {`N_REQ{1'b0}};
            svc[k] = 1'b1;
            svc_id = k[2:0];
        end
    end
    // stalled by global enable or full stack
    if (!global_irq_enable_r || stack_full) begin
        svc = {`N_REQ{1'b0}};
    end
end

wire call = |svc;

// ----------------------------------------------------------------
// Top-level flags
// ----------------------------------------------------------------
wire protect_set = oc_s & ~oc_prev_r;
wire lvd_set = lvd_s & ~lvd_prev_r;

// set by overcurrent, cleared on service
wire protect_nxt = protect_set |
    (protect_irq_flag_r & ~svc[0] & ~(wr_flag & zero_bits[0]));
// low supply set and service clear
wire lvd_nxt = lvd_set |
    (low_supply_flag_r & ~svc[1] & ~(wr_flag & zero_bits[2]));
wire tick_nxt = tick_pulse |
    (tick_flag_r & ~svc[6] & ~(wr_flag & zero_bits[1]));
// service clears only the group flag
wire [3:0] grp_nxt = grp_set |
    (group_irq_flag_r & ~svc[5:2] & ~({4{wr_flag}} & zero_bits[7:4]));

// global cleared on call, set by return
wire global_nxt = call ? 1'b0 :
                    reti_evt ? 1'b1 :
                    wr_core ? reg_wdata[0] :
                    global_irq_enable_r;

wire [MW+6:0] all_now = {mem_flag_r, group_irq_flag_r, tick_flag_r,
                         low_supply_flag_r, protect_irq_flag_r};
wire [MW+6:0] all_nxt = {mem_nxt, grp_nxt, tick_nxt, lvd_nxt, protect_nxt};
wire wake_nxt = |(all_nxt & ~all_now);

always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        protect_irq_flag_r <= 1'b0;
        low_supply_flag_r <= 1'b0;
        tick_flag_r <= 1'b0;
        group_irq_flag_r <= 4'h0;
        mem_flag_r <= {MW{1'b0}};
        global_irq_enable_r <= 1'b0;
        vec_call_r <= 1'b0;
        vec_id_r <= `VEC_PROTECT;
        wake_r <= 1'b0;
        oc_prev_r <= 1'b0;
        lvd_prev_r <= 1'b0;
        sub_prev_r <= 1'b0;
    end else begin
        oc_prev_r <= oc_s;
        lvd_prev_r <= lvd_s;
        sub_prev_r <= sub_s;
        protect_irq_flag_r <= protect_nxt;
        low_supply_flag_r <= lvd_nxt;
        tick_flag_r <= tick_nxt;
        group_irq_flag_r <= grp_nxt;
        mem_flag_r <= mem_nxt;
        global_irq_enable_r <= global_nxt;
        vec_call_r <= call;
        if (call) begin
            vec_id_r <= svc_id;
        end
        wake_r <= wake_nxt;
    end
end

// ----------------------------------------------------------------
// Control registers
// ----------------------------------------------------------------
always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        prescaler_source_r <= `PSC_SRC_RST;
        tick_generator_on_r <= 1'b0;
        tick_period_select_r <= 3'h0;
        protect_irq_enable_r <= 1'b0;
        tick_irq_enable_r <= 1'b0;
        low_supply_enable_r <= 1'b0;
        group_en_r <= 4'h0;
        upper_bound_trigger_en_r <= 1'b0;
        lower_bound_trigger_en_r <= 1'b0;
        upper_bound_r <= `REG8_RST;
        lower_bound_r <= `REG8_RST;
        mem_en_r <= {MW{1'b0}};
    end else begin
        if (reg_wr && reg_addr == `OFS_PSC_SRC) begin
            prescaler_source_r <= reg_wdata[1:0];
        end
        if (reg_wr && reg_addr == `OFS_TICK_CTRL) begin
            tick_generator_on_r <= reg_wdata[`TICK_ON_BIT];
            tick_period_select_r <= reg_wdata[2:0];
        end
        if (wr_en) begin
            protect_irq_enable_r <= reg_wdata[0];
            tick_irq_enable_r <= reg_wdata[1];
            low_supply_enable_r <= reg_wdata[2];
            group_en_r <= reg_wdata[7:4];
        end
        if (wr_conv) begin
            mem_en_r[1:0] <= reg_wdata[1:0];
            upper_bound_trigger_en_r <= reg_wdata[2];
            lower_bound_trigger_en_r <= reg_wdata[3];
        end
        if (reg_wr && reg_addr == `OFS_UPPER_BOUND) begin
            upper_bound_r <= reg_wdata;
        end
        if (reg_wr && reg_addr == `OFS_LOWER_BOUND) begin
            lower_bound_r <= reg_wdata;
        end
        if (wr_cap) begin
            mem_en_r[3:2] <= reg_wdata[1:0];
        end
        if (wr_pwm) begin
            mem_en_r[7:4] <= reg_wdata[3:0];
        end
        if (wr_tmr_en) begin
            mem_en_r[MW-1:8] <= reg_wdata[TW-1:0];
        end
    end
end

// ----------------------------------------------------------------
// Read path
// ----------------------------------------------------------------
reg [7:0] rd_nxt;

always @* begin
    rd_nxt = 8'h00;
    case (reg_addr)
        `OFS_PSC_SRC: rd_nxt = {6'h00, prescaler_source_r};
        `OFS_TICK_CTRL: rd_nxt = {tick_generator_on_r, 4'h0,
                                  tick_period_select_r};
        `OFS_CORE_CTRL: rd_nxt = {7'h00, global_irq_enable_r};
        `OFS_IRQ_EN: rd_nxt = {group_en_r, 1'b0, low_supply_enable_r,
                               tick_irq_enable_r, protect_irq_enable_r};
        `OFS_IRQ_FLAG: rd_nxt = {group_irq_flag_r, 1'b0, low_supply_flag_r,
                                 tick_flag_r, protect_irq_flag_r};
        `OFS_CONV_CTRL: rd_nxt = {mem_flag_r[1:0], 2'h0,
                                  lower_bound_trigger_en_r,
                                  upper_bound_trigger_en_r, mem_en_r[1:0]};
        `OFS_UPPER_BOUND: rd_nxt = upper_bound_r;
        `OFS_LOWER_BOUND: rd_nxt = lower_bound_r;
        `OFS_CAPTURE: rd_nxt = {2'h0, mem_flag_r[3:2], 2'h0, mem_en_r[3:2]};
        `OFS_PWM: rd_nxt = {mem_flag_r[7:4], mem_en_r[7:4]};
        `OFS_TMR_EN: rd_nxt[TW-1:0] = mem_en_r[MW-1:8];
        `OFS_TMR_FLAG: rd_nxt[TW-1:0] = mem_flag_r[MW-1:8];
        `OFS_STATUS: rd_nxt = {4'h0, vec_id_r, stack_full};
        default: rd_nxt = 8'h00;
    endcase
end

// Data stand only in the cycle after the read strobe.
always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        rd_data_r <= 8'h00;
    end else begin
        rd_data_r <= reg_rd ? rd_nxt : 8'h00;
    end
end

endmodule

// ===== irq_ctrl_monitor.sv
// Concurrent checks on the vectoring outputs and register reads of irq_ctrl.
// Assumes one clock domain and the core partner on stack_full and reti_evt.
`timescale 1ns/1ps
`include "irq_consts.vh"

module irq_ctrl_monitor (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] rd_data_r,
    input wire logic stack_full,
    input wire logic reti_evt,
    input wire logic vec_call_r,
    input wire logic [2:0] vec_id_r,
    input wire logic global_irq_enable_r
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // ----------------------------------------------------------------
    // Vectoring
    // ----------------------------------------------------------------
    // A call is one step after an open gate; a return is seen one step later
    sequence svc_taken;
        global_irq_enable_r && !stack_full ##1 vec_call_r;
    endsequence
    sequence ret_seen;
        reti_evt ##1 !vec_call_r;
    endsequence

    call_gated_a: assert property (
        vec_call_r |-> $past(global_irq_enable_r) && !$past(stack_full))
        else $error("vector call with gate closed");
    call_clears_global_a: assert property (
        svc_taken |-> !global_irq_enable_r)
        else $error("global enable left set by a call");
    single_call_a: assert property (
        vec_call_r |=> !vec_call_r)
        else $error("two calls in a row");
    vec_id_legal_a: assert property (
        vec_call_r |-> vec_id_r <= `VEC_TICK)
        else $error("vector id out of range");
    reti_reopens_a: assert property (
        ret_seen |-> global_irq_enable_r)
        else $error("return did not set global enable");
    global_cause_a: assert property (
        $rose(global_irq_enable_r) |-> $past(reti_evt)
            || $past(reg_wr && reg_addr == `OFS_CORE_CTRL && reg_wdata[0]))
        else $error("global enable set without cause");

    // ----------------------------------------------------------------
    // Unused register bits
    // ----------------------------------------------------------------
    psc_spare_zero_a: assert property (
        reg_rd && reg_addr == `OFS_PSC_SRC |=> rd_data_r[7:2] == 6'h00)
        else $error("prescaler spare bits not zero");
    tick_spare_zero_a: assert property (
        reg_rd && reg_addr == `OFS_TICK_CTRL |=> rd_data_r[6:3] == 4'h0)
        else $error("tick control spare bits not zero");

    cover property (vec_call_r && vec_id_r == `VEC_PROTECT);
endmodule

bind irq_ctrl irq_ctrl_monitor u_mon (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .rd_data_r(rd_data_r), .stack_full(stack_full),
    .reti_evt(reti_evt), .vec_call_r(vec_call_r), .vec_id_r(vec_id_r),
    .global_irq_enable_r(global_irq_enable_r)
);

// ===== core_model.sv
// Processor core model: answers vector calls and reports stack room.
// Assumes vec_call_r is a one-cycle pulse; service length is set per test.
`timescale 1ns/1ps

module core_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic vec_call_r,
    input wire logic full_req,
    input wire logic use_reti,
    input wire logic [3:0] svc_len,
    output logic stack_full,
    output logic reti_evt,
    output logic [15:0] n_calls
);
    logic [3:0] wait_r;

    // ----------------------------------------------------------------
    // Service and return
    // ----------------------------------------------------------------
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stack_full <= 1'b0;
            reti_evt <= 1'b0;
            n_calls <= 16'h0000;
            wait_r <= 4'h0;
        end else begin
            stack_full <= full_req;
            reti_evt <= 1'b0;
            if (vec_call_r) begin
                n_calls <= n_calls + 16'h0001;
                wait_r <= svc_len;
            end else if (wait_r != 4'h0) begin
                wait_r <= wait_r - 4'h1;
                if (wait_r == 4'h1) begin
                    reti_evt <= use_reti;
                end
            end
        end
    end
endmodule

// ===== irq_sources_and_time_base_tb.sv
// Self-checking bench for irq_ctrl with the core model on its far side.
// Assumes a 100 MHz sys_clk and a free sub clock of eight sys_clk periods.
`timescale 1ns/1ps
`include "irq_consts.vh"

module irq_sources_and_time_base_tb;
    logic sys_clk = 1'b0, rst = 1'b1, sub_clk = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic ocp = 1'b0, low_v = 1'b0, full_req = 1'b0, use_reti = 1'b1;
    logic [4:0] reg_addr = 5'h00;
    logic [7:0] reg_wdata = 8'h00, conv_result = 8'h00, rv;
    logic [10:0] ev = 11'h000;
    logic [3:0] svc_len = 4'h1;
    wire logic [7:0] rd_data_r;
    wire logic [2:0] vec_id_r;
    wire logic vec_call_r, wake_r, global_irq_enable_r, stack_full, reti_evt;
    wire logic [15:0] n_calls;
    integer err_count = 0, n_compared = 0, n_wake = 0, gap, snap, i;
    int exp_t [6] = '{256, 512, 2048, 1024, 2048, 2048};
    logic [7:0] psc_t [6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h03};
    logic [7:0] ctl_t [6] = '{8'h80, 8'h81, 8'h83, 8'h80, 8'h80, 8'h80};

    irq_ctrl #(.N_TMR(2)) u_dut (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .rd_data_r(rd_data_r),
        .overcurrent_protect_signal(ocp), .low_supply_detect(low_v), .sub_clk(sub_clk),
        .conv_done_evt(ev[0]), .conv_result(conv_result), .capture_overflow_evt(ev[1]),
        .capture_compare_evt(ev[2]), .period_match_evt(ev[3]), .duty_match_evt(ev[6:4]),
        .timer_p_match_evt(ev[8:7]), .timer_a_match_evt(ev[10:9]),
        .stack_full(stack_full), .reti_evt(reti_evt), .vec_call_r(vec_call_r),
        .vec_id_r(vec_id_r), .wake_r(wake_r), .global_irq_enable_r(global_irq_enable_r));
    core_model u_core (.sys_clk(sys_clk), .rst(rst), .vec_call_r(vec_call_r),
        .full_req(full_req), .use_reti(use_reti), .svc_len(svc_len),
        .stack_full(stack_full), .reti_evt(reti_evt), .n_calls(n_calls));

    always #5 sys_clk = ~sys_clk;
    always #40 sub_clk = ~sub_clk;
    always @(posedge sys_clk) if (wake_r === 1'b1) n_wake <= n_wake + 1;

    // ----------------------------------------------------------------
    // Access and compare tasks
    // ----------------------------------------------------------------
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task rc(input logic [4:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rv = rd_data_r;
        chk($sformatf("reg_%0h", a), exp, rv);
    endtask
    task pulse(input logic [10:0] m);
        @(posedge sys_clk);
        ev <= m;
        @(posedge sys_clk);
        ev <= 11'h000;
    endtask
    // Waits for the next call and counts the cycles since the task began
    task wait_call(input logic [2:0] id);
        gap = 0;
        do begin
            @(posedge sys_clk);
            #1 gap = gap + 1;
        end while (vec_call_r !== 1'b1 && gap < 5000);
        chk("vec_call", 1'b1, vec_call_r);
        chk("vec_id", id, vec_id_r);
    endtask
    // Two calls first, so a stale flag from a reconfiguration is flushed
    task measure(input int exp);
        wait_call(`VEC_TICK);
        wait_call(`VEC_TICK);
        wait_call(`VEC_TICK);
        chk("tick_gap", exp, gap);
    endtask
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge sys_clk);
        err_count = err_count + 1;
        end_sim;
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        rc(`OFS_PSC_SRC, 8'h00);
        rc(`OFS_TICK_CTRL, 8'h00);
        wr(`OFS_PSC_SRC, 8'hFF);
        rc(`OFS_PSC_SRC, 8'h03);
        wr(`OFS_TICK_CTRL, 8'hFF);
        rc(`OFS_TICK_CTRL, 8'h87);
        rc(5'h1F, 8'h00);
        wr(`OFS_IRQ_EN, 8'h02);
        wr(`OFS_CORE_CTRL, 8'h01);
        for (i = 0; i < 6; i = i + 1) begin
            wr(`OFS_PSC_SRC, psc_t[i]);
            wr(`OFS_TICK_CTRL, ctl_t[i]);
            measure(exp_t[i]);
        end
        wr(`OFS_PSC_SRC, 8'h00);
        wr(`OFS_TICK_CTRL, 8'h80);
        full_req <= 1'b1;
        repeat (3) @(posedge sys_clk);
        snap = n_calls;
        repeat (600) @(posedge sys_clk);
        chk("calls_full", snap, n_calls);
        full_req <= 1'b0;
        wait_call(`VEC_TICK);
        use_reti <= 1'b0;
        repeat (600) @(posedge sys_clk);
        rc(`OFS_CORE_CTRL, 8'h00);
        use_reti <= 1'b1;
        wr(`OFS_CORE_CTRL, 8'h01);
        wait_call(`VEC_TICK);
        wr(`OFS_TICK_CTRL, 8'h00);
        wr(`OFS_IRQ_FLAG, 8'h00);
        repeat (2) @(posedge sys_clk);
        snap = n_calls;
        repeat (600) @(posedge sys_clk);
        chk("calls_off", snap, n_calls);
        // Three sources pending at once, released by one global write
        wr(`OFS_CORE_CTRL, 8'h00);
        wr(`OFS_IRQ_EN, 8'h45);
        wr(`OFS_PWM, 8'h01);
        svc_len <= 4'h9;
        ocp <= 1'b1;
        low_v <= 1'b1;
        pulse(11'h008);
        repeat (6) @(posedge sys_clk);
        wr(`OFS_CORE_CTRL, 8'h01);
        wait_call(`VEC_PROTECT);
        wait_call(`VEC_LOW_SUPPLY);
        wait_call(`VEC_GROUP0 + 3'h2);
        ocp <= 1'b0;
        low_v <= 1'b0;
        repeat (12) @(posedge sys_clk);
        rc(`OFS_IRQ_FLAG, 8'h00);
        rc(`OFS_PWM, 8'h11);
        wr(`OFS_PWM, 8'h01);
        rc(`OFS_PWM, 8'h01);
        snap = n_wake;
        pulse(11'h006);
        rc(`OFS_CAPTURE, 8'h30);
        chk("wake", 1'b1, n_wake > snap);
        wr(`OFS_CAPTURE, 8'h00);
        rc(`OFS_CAPTURE, 8'h00);
        pulse(11'h070);
        rc(`OFS_PWM, 8'hE1);
        pulse(11'h780);
        rc(`OFS_TMR_FLAG, 8'h0F);
        wr(`OFS_TMR_FLAG, 8'h00);
        rc(`OFS_TMR_FLAG, 8'h00);
        wr(`OFS_UPPER_BOUND, 8'h80);
        wr(`OFS_LOWER_BOUND, 8'h10);
        wr(`OFS_CONV_CTRL, 8'h06);
        conv_result <= 8'h90;
        pulse(11'h001);
        repeat (12) @(posedge sys_clk);
        rc(`OFS_CONV_CTRL, 8'hC6);
        wr(`OFS_CONV_CTRL, 8'h0E);
        conv_result <= 8'h08;
        pulse(11'h001);
        rc(`OFS_CONV_CTRL, 8'hCE);
        wr(`OFS_CONV_CTRL, 8'h0E);
        conv_result <= 8'h50;
        pulse(11'h001);
        rc(`OFS_CONV_CTRL, 8'h4E);
        end_sim;
    end
endmodule
